// ===== design/hmct_pkg.sv
/*
  Shared constants for the hub memory cycle target and its master end.
  Assumes one 200 MHz clock shared by both ends and a 4-bit nibble bus.
*/
package hmct_pkg;
  localparam logic [3:0] START_READ = 4'hd;
  localparam logic [3:0] START_WRITE = 4'he;
  localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;
  localparam logic [3:0] TURN_NIBBLE = 4'hf;
  localparam logic [3:0] WAIT_SYNC = 4'h5;
  localparam logic [3:0] READY_SYNC = 4'h0;
  localparam int ADDR_NIBBLES = 7;
  localparam int ADDR_BITS = 28;
  localparam int DECODE_BITS = 24;
  localparam int ARRAY_SEL_BIT = 22;
  localparam int WAIT_CLOCKS = 2;
  localparam logic [3:0] STRAP_RESET = 4'h0;
endpackage : hmct_pkg

// ===== design/hmct_link_if.sv
/*
  Nibble bus carrier between the master end and the target end.
  Assumes both ends share ref_clk; the wire value is resolved here.
*/
`timescale 1ns/100ps
interface hmct_link_if;
  logic frame_strobe_n;
  logic [3:0] mst_nibble_out;
  logic mst_nibble_oe;
  logic [3:0] tgt_nibble_out;
  logic tgt_nibble_oe;
  logic [3:0] nibble_bus;

  // Wire level: whoever drives wins, master first if both drive, pull-ups otherwise
  assign nibble_bus = mst_nibble_oe ? mst_nibble_out :
                      (tgt_nibble_oe ? tgt_nibble_out : 4'hf);

  modport master (
    output frame_strobe_n,
    output mst_nibble_out,
    output mst_nibble_oe,
    input nibble_bus
  );
  modport target (
    input frame_strobe_n,
    output tgt_nibble_out,
    output tgt_nibble_oe,
    input nibble_bus
  );
endinterface : hmct_link_if

// ===== design/hmct_target.sv
/*
  Target end: decodes hub read and write cycles on the nibble bus.
  Assumes the master end keeps its own field order and timing.
// Contract
// - Reset leaves array-read mode active
// - Master opens read with start 1101b
// - Respond only if strobe low at start
// - Start is last nibble while strobe low
// - Next clock: select must equal strap pins
// - Seven address nibbles, most significant first
// - Size nibble must be 0000b
// - Master drives 1111b then releases
// - Target drives bus in second turnaround
// - Drive wait sync while data pending
// - Ready sync, then byte over two clocks
// - Low nibble first, high nibble next
// - After data: 1111b then float
// - Master opens write with start 1110b
// - Write data low nibble first
// - Written byte is command or program data
// - Master turnaround after write data
// - Write acknowledged by ready sync, clock 15
// - Two-clock turnaround ends write, clock 17
// - Fields valid at the rising edge
// - Decode low 24 bits, bit 22 array
// - Bad start: float, go to standby
// - Strobe active: stop driving next clock
*/
`timescale 1ns/100ps
module hmct_target #(
  parameter int WAIT_CLOCKS = hmct_pkg::WAIT_CLOCKS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link
  hmct_link_if.target link,
  // Straps
  input wire logic [3:0] select_strap_pins,
  // Memory side
  output logic mem_rd_req,
  output logic [23:0] mem_addr,
  output logic mem_array_sel,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_req,
  output logic [7:0] mem_wr_data,
  output logic array_read_mode,
  output logic standby
);
  typedef enum logic [11:0] {
    S_IDLE = 12'h001, S_SELECT = 12'h002, S_ADDR = 12'h004,
    S_SIZE = 12'h008, S_WDATA = 12'h010, S_TURN0 = 12'h020,
    S_TURN1 = 12'h040, S_WAIT = 12'h080, S_READY = 12'h100,
    S_DATA = 12'h200, S_BACK0 = 12'h400, S_BACK1 = 12'h800
  } hmct_tstate_t;

  hmct_tstate_t state_reg;
  logic is_write_reg;
  logic [2:0] cnt_reg;
  logic [27:0] addr_reg;
  logic [7:0] data_reg;
  logic [3:0] strap_reg;
  logic size_ok_reg;
  logic [3:0] nib_out_reg;
  logic oe_reg;
  logic [3:0] nib;
  logic strobe_low;

  assign nib = link.nibble_bus;
  assign strobe_low = !link.frame_strobe_n;

  // Strap capture on every clock, reset to a known value
  always_ff @(posedge ref_clk)
    if (rst)
      strap_reg <= hmct_pkg::STRAP_RESET;
    else
      strap_reg <= select_strap_pins;

  // Field sequencer; nibbles sampled at rising edge
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      is_write_reg <= 1'b0;
      cnt_reg <= 3'h0;
      addr_reg <= 28'h0;
      size_ok_reg <= 1'b0;
      data_reg <= 8'h00;
    end
    else if (strobe_low)
    begin
      // Last low-strobe nibble is the start
      if (nib == hmct_pkg::START_READ || nib == hmct_pkg::START_WRITE)
      begin
        state_reg <= S_SELECT;
        is_write_reg <= (nib == hmct_pkg::START_WRITE);
      end
      else
        state_reg <= S_IDLE; // Unknown start ignored
    end
    else
    begin
      case (state_reg)
        S_IDLE: state_reg <= S_IDLE;
        S_SELECT:
        begin
          cnt_reg <= 3'h0;
          // Exact strap match or abandon the cycle
          state_reg <= (nib == strap_reg) ? S_ADDR : S_IDLE;
        end
        S_ADDR:
        begin
          addr_reg <= {addr_reg[23:0], nib}; // Most significant first
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'(hmct_pkg::ADDR_NIBBLES - 1))
            state_reg <= S_SIZE;
        end
        S_SIZE:
        begin
          size_ok_reg <= (nib == hmct_pkg::SIZE_ONE_BYTE);
          cnt_reg <= 3'h0;
          state_reg <= is_write_reg ? S_WDATA : S_TURN0;
        end
        S_WDATA:
        begin
          // Low nibble first
          data_reg <= {nib, data_reg[7:4]};
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h1)
            state_reg <= S_TURN0;
        end
        S_TURN0: state_reg <= S_TURN1; // Master drives 1111b
        S_TURN1:
        begin
          cnt_reg <= 3'h0;
          if (is_write_reg || WAIT_CLOCKS == 0)
            state_reg <= S_READY;
          else
            state_reg <= S_WAIT;
        end
        S_WAIT:
        begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'(WAIT_CLOCKS - 1))
            state_reg <= S_READY; // Wait length from access time
        end
        S_READY:
        begin
          cnt_reg <= 3'h0;
          if (is_write_reg)
            state_reg <= S_BACK0;
          else
          begin
            data_reg <= mem_rd_data;
            state_reg <= S_DATA;
          end
        end
        S_DATA:
        begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h1)
            state_reg <= S_BACK0;
        end
        S_BACK0: state_reg <= S_BACK1;
        S_BACK1: state_reg <= S_IDLE; // Write ends at clock 17
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Nibble drive for the coming clock
  always_ff @(posedge ref_clk)
  begin
    if (rst || strobe_low)
    begin
      oe_reg <= 1'b0; // Release on active strobe
      nib_out_reg <= hmct_pkg::TURN_NIBBLE;
    end
    else
    begin
      oe_reg <= 1'b0;
      nib_out_reg <= hmct_pkg::TURN_NIBBLE;
      case (state_reg)
        S_TURN0:
        begin
          oe_reg <= 1'b1; // Take bus in second turnaround
          nib_out_reg <= hmct_pkg::TURN_NIBBLE;
        end
        S_TURN1, S_WAIT:
        begin
          oe_reg <= 1'b1;
          if (is_write_reg ||
              (state_reg == S_WAIT && cnt_reg == 3'(WAIT_CLOCKS - 1)) ||
              (state_reg == S_TURN1 && WAIT_CLOCKS == 0))
            nib_out_reg <= hmct_pkg::READY_SYNC;
          else
            nib_out_reg <= hmct_pkg::WAIT_SYNC;
        end
        S_READY:
        begin
          oe_reg <= 1'b1;
          // Write goes to turnaround; read sends low nibble
          nib_out_reg <= is_write_reg ? hmct_pkg::TURN_NIBBLE
                                      : mem_rd_data[3:0];
        end
        S_DATA:
        begin
          oe_reg <= 1'b1;
          nib_out_reg <= (cnt_reg == 3'h0) ? data_reg[7:4]
                                           : hmct_pkg::TURN_NIBBLE;
        end
        default:
        begin
          oe_reg <= 1'b0; // Floats in turnaround second clock
          nib_out_reg <= hmct_pkg::TURN_NIBBLE;
        end
      endcase
    end
  end

  // Memory side requests
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mem_rd_req <= 1'b0;
      mem_wr_req <= 1'b0;
      mem_wr_data <= 8'h00;
      array_read_mode <= 1'b1; // Array read after reset
    end
    else
    begin
      mem_rd_req <= !strobe_low && state_reg == S_TURN0 && !is_write_reg
                    && size_ok_reg;
      // Written byte handed on as command or data
      mem_wr_req <= !strobe_low && state_reg == S_READY && is_write_reg
                    && size_ok_reg;
      mem_wr_data <= data_reg;
      array_read_mode <= 1'b1;
    end
  end

  // Low 24 bits decoded, bit 22 picks array
  assign mem_addr = addr_reg[hmct_pkg::DECODE_BITS-1:0];
  assign mem_array_sel = addr_reg[hmct_pkg::ARRAY_SEL_BIT];
  assign standby = (state_reg == S_IDLE) && !strobe_low;
  assign link.tgt_nibble_out = nib_out_reg;
  assign link.tgt_nibble_oe = oe_reg;
endmodule : hmct_target

// ===== design/hmct_master.sv
/*
  Master end: issues one hub read or write cycle per request.
  Assumes the target end answers with sync nibbles as documented.
*/
`timescale 1ns/100ps
module hmct_master (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link
  hmct_link_if.master link,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [3:0] req_select,
  input wire logic [27:0] req_addr,
  input wire logic [7:0] req_wdata,
  // User answer
  output logic done,
  output logic [7:0] rdata
);
  typedef enum logic [8:0] {
    M_IDLE = 9'h001, M_SELECT = 9'h002, M_ADDR = 9'h004,
    M_SIZE = 9'h008, M_WDATA = 9'h010, M_TURN0 = 9'h020,
    M_SYNC = 9'h040, M_RDATA = 9'h080, M_BACK = 9'h100
  } hmct_mstate_t;

  hmct_mstate_t state_reg;
  logic write_reg;
  logic [2:0] cnt_reg;
  logic [3:0] sel_reg;
  logic [27:0] addr_reg;
  logic [7:0] data_reg;
  logic strobe_n_reg;
  logic [3:0] out_reg;
  logic oe_reg;

  assign req_ready = (state_reg == M_IDLE);

  // Cycle sequencer, one nibble per clock
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= M_IDLE;
      write_reg <= 1'b0;
      cnt_reg <= 3'h0;
      sel_reg <= 4'h0;
      addr_reg <= 28'h0;
      data_reg <= 8'h00;
      strobe_n_reg <= 1'b1;
      out_reg <= 4'hf;
      oe_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        M_IDLE:
        begin
          oe_reg <= 1'b0;
          strobe_n_reg <= 1'b1;
          if (req_valid)
          begin
            // Start nibble with strobe low
            strobe_n_reg <= 1'b0;
            oe_reg <= 1'b1;
            out_reg <= req_write ? hmct_pkg::START_WRITE
                                 : hmct_pkg::START_READ;
            write_reg <= req_write;
            sel_reg <= req_select;
            addr_reg <= req_addr;
            data_reg <= req_wdata;
            state_reg <= M_SELECT;
          end
        end
        M_SELECT:
        begin
          strobe_n_reg <= 1'b1;
          out_reg <= sel_reg;
          cnt_reg <= 3'h0;
          state_reg <= M_ADDR;
        end
        M_ADDR:
        begin
          out_reg <= addr_reg[27:24]; // Most significant first
          addr_reg <= {addr_reg[23:0], 4'h0};
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'(hmct_pkg::ADDR_NIBBLES - 1))
            state_reg <= M_SIZE;
        end
        M_SIZE:
        begin
          out_reg <= hmct_pkg::SIZE_ONE_BYTE;
          cnt_reg <= 3'h0;
          state_reg <= write_reg ? M_WDATA : M_TURN0;
        end
        M_WDATA:
        begin
          out_reg <= data_reg[3:0]; // Low nibble first
          data_reg <= {4'h0, data_reg[7:4]};
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h1)
            state_reg <= M_TURN0;
        end
        M_TURN0:
        begin
          out_reg <= hmct_pkg::TURN_NIBBLE;
          state_reg <= M_SYNC;
        end
        M_SYNC:
        begin
          oe_reg <= 1'b0; // Released for second turnaround
          cnt_reg <= 3'h0;
          if (!oe_reg && link.nibble_bus == hmct_pkg::READY_SYNC)
            state_reg <= write_reg ? M_BACK : M_RDATA;
        end
        M_RDATA:
        begin
          data_reg <= {link.nibble_bus, data_reg[7:4]};
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h1)
          begin
            rdata <= {link.nibble_bus, data_reg[7:4]};
            state_reg <= M_BACK;
          end
        end
        M_BACK:
        begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h0)
            cnt_reg <= 3'h1;
          else
          begin
            done <= 1'b1; // Bus returned after target turnaround
            state_reg <= M_IDLE;
          end
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end

  assign link.frame_strobe_n = strobe_n_reg;
  assign link.mst_nibble_out = out_reg;
  assign link.mst_nibble_oe = oe_reg;
endmodule : hmct_master

// ===== bench/hmct_link_assertions.sv
/*
  Checker on the nibble link between the master and target ends.
  Assumes one clock, synchronous reset and the default two wait clocks.
*/
`timescale 1ns/100ps
module hmct_link_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link signals
  input wire logic frame_strobe_n,
  input wire logic [3:0] mst_nibble_out,
  input wire logic mst_nibble_oe,
  input wire logic [3:0] tgt_nibble_out,
  input wire logic tgt_nibble_oe,
  input wire logic [3:0] nibble_bus
);
  logic [3:0] start_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Last nibble seen while the strobe is low
  always_ff @(posedge ref_clk)
  begin
    if (!frame_strobe_n)
    begin
      start_reg <= nibble_bus;
    end
  end
  a_no_contention: assert property (!(mst_nibble_oe && tgt_nibble_oe))
    else $error("both ends drive the bus");
  a_master_turn_ones: assert property ($fell(mst_nibble_oe) |->
    $past(mst_nibble_out) == hmct_pkg::TURN_NIBBLE)
    else $error("master released without ones");
  a_size_one_byte: assert property ($rose(frame_strobe_n) |->
    ##8 nibble_bus == hmct_pkg::SIZE_ONE_BYTE)
    else $error("size nibble not single byte");
  a_quiet_early: assert property ($rose(frame_strobe_n) |->
    !tgt_nibble_oe [*8])
    else $error("target drove before turnaround");
  a_read_take_over: assert property ($rose(frame_strobe_n) &&
    start_reg == hmct_pkg::START_READ |-> ##10 tgt_nibble_oe ##1
    (tgt_nibble_oe && tgt_nibble_out == hmct_pkg::WAIT_SYNC) [*2] ##1
    (tgt_nibble_oe && tgt_nibble_out == hmct_pkg::READY_SYNC))
    else $error("read sync sequence wrong");
  a_read_give_back: assert property ($rose(frame_strobe_n) &&
    start_reg == hmct_pkg::START_READ |-> ##16
    (tgt_nibble_oe && tgt_nibble_out == hmct_pkg::TURN_NIBBLE) ##1
    !tgt_nibble_oe)
    else $error("read turnaround wrong");
  a_write_ack_sync: assert property ($rose(frame_strobe_n) &&
    start_reg == hmct_pkg::START_WRITE |-> ##13
    (tgt_nibble_oe && tgt_nibble_out == hmct_pkg::READY_SYNC))
    else $error("write ready sync missing");
  a_write_give_back: assert property ($rose(frame_strobe_n) &&
    start_reg == hmct_pkg::START_WRITE |-> ##14
    (tgt_nibble_oe && tgt_nibble_out == hmct_pkg::TURN_NIBBLE) ##1
    !tgt_nibble_oe)
    else $error("write turnaround wrong");
  a_strobe_stops_drive: assert property (!frame_strobe_n |=>
    !tgt_nibble_oe)
    else $error("target drove after strobe");
  // Main scenarios reached
  c_read: cover property (tgt_nibble_oe && tgt_nibble_out == 4'h5);
  c_write: cover property (start_reg == hmct_pkg::START_WRITE);
  c_start: cover property ($rose(frame_strobe_n));
endmodule : hmct_link_assertions

// ===== bench/hub_memory_cycle_target_test.sv
/*
  Bench: master and target joined by one link, plus a second target whose
  link the bench drives itself to break the protocol.
  Assumes the default wait count and the package constants.
*/
`timescale 1ns/100ps
module hub_memory_cycle_target_test;
  localparam logic [3:0] RD = hmct_pkg::START_READ;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [27:0] req_addr = 28'h0;
  logic [7:0] req_wdata = 8'h0;
  logic [3:0] strap = 4'ha;
  logic [7:0] rd_data = 8'h00;
  logic req_ready, done, rd_req, wr_req, sel, arm, rd_req2, stby2;
  logic [7:0] rdata, wr_data;
  logic [23:0] addr, rd_addr;
  logic [3:0] wire_q [32];
  logic [3:0] st_t [6] = '{RD, RD, 4'h3, RD, RD, RD};
  logic [3:0] sl_t [6] = '{4'h5, 4'h6, 4'h5, 4'h5, 4'h5, 4'h5};
  logic [3:0] sz_t [6] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0};
  int lo_t [6] = '{3, 1, 1, 1, 0, 1};
  // Target drive clocks per frame: full read 7, cut in first wait 2
  int oe_t [6] = '{7, 0, 0, 7, 0, 2};
  int rq_t [6] = '{1, 0, 0, 0, 0, 1};
  int ct_t [6] = '{0, 0, 0, 0, 0, 1};
  int pos = 0;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int rd_n = 0;
  int wr_n = 0;
  int oe2_n = 0;
  int rd2_n = 0;
  hmct_link_if lk ();
  hmct_link_if lk2 ();
  hmct_master hmct_master_i (.ref_clk(ref_clk), .rst(rst), .link(lk.master),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_select(strap), .req_addr(req_addr), .req_wdata(req_wdata),
    .done(done), .rdata(rdata));
  hmct_target hmct_target_i (.ref_clk(ref_clk), .rst(rst), .link(lk.target),
    .select_strap_pins(strap), .mem_rd_req(rd_req), .mem_addr(addr),
    .mem_array_sel(sel), .mem_rd_data(rd_data), .mem_wr_req(wr_req),
    .mem_wr_data(wr_data), .array_read_mode(arm), .standby());
  hmct_target hmct_target_i2 (.ref_clk(ref_clk), .rst(rst),
    .link(lk2.target), .select_strap_pins(4'h5), .mem_rd_req(rd_req2),
    .mem_addr(), .mem_array_sel(), .mem_rd_data(8'h00), .mem_wr_req(),
    .mem_wr_data(), .array_read_mode(), .standby(stby2));
  hmct_link_assertions hmct_link_assertions_i (.ref_clk(ref_clk), .rst(rst),
    .frame_strobe_n(lk.frame_strobe_n), .mst_nibble_out(lk.mst_nibble_out),
    .mst_nibble_oe(lk.mst_nibble_oe), .tgt_nibble_out(lk.tgt_nibble_out),
    .tgt_nibble_oe(lk.tgt_nibble_oe), .nibble_bus(lk.nibble_bus));
  // Clock at 200 MHz
  always #2.5 ref_clk = ~ref_clk;
  // Record the wire by clock of the frame, count requests and second-target drive clocks, cut hangs short
  always @(posedge ref_clk)
  begin
    cycles++;
    pos = !lk.frame_strobe_n ? 1 : (pos < 31 ? pos + 1 : pos);
    wire_q[pos] = lk.nibble_bus;
    rd_addr = rd_req ? addr : rd_addr;
    rd_n += int'(rd_req);
    wr_n += int'(wr_req);
    oe2_n += int'(lk2.tgt_nibble_oe);
    rd2_n += int'(rd_req2);
    if (cycles == 3000)
    begin
      fails++;
      complete_run();
    end
  end
  task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic run_cycle(input logic wr, input logic [27:0] a,
                           input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge ref_clk);
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge ref_clk);
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 80)
    begin
      @(negedge ref_clk);
      n++;
    end
    cmp_val(24'(done), 24'h1);
  endtask : run_cycle
  task automatic frame2(input logic [3:0] st, input logic [3:0] sl,
                        input logic [3:0] sz, input int low,
                        input int cut);
    logic [3:0] f [11];
    int lead;
    f = '{st, sl, 4'h0, 4'h4, 4'h0, 4'h0, 4'h1, 4'h2, 4'h3, sz, 4'hf};
    lead = low > 1 ? low - 1 : 0;
    oe2_n = 0;
    rd2_n = 0;
    for (int i = 0; i < lead + 11; i++)
    begin
      @(negedge ref_clk);
      lk2.mst_nibble_oe = 1'b1;
      lk2.mst_nibble_out = i < lead ? 4'h3 : f[i - lead];
      lk2.frame_strobe_n = !(low > 0 && i <= lead);
    end
    @(negedge ref_clk);
    lk2.mst_nibble_oe = 1'b0;
    // Optional one-clock strobe pulse while the target drives wait sync
    for (int i = 1; i <= 12; i++)
    begin
      @(negedge ref_clk);
      lk2.frame_strobe_n = (i != cut);
    end
  endtask : frame2
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // Main sequence
  initial
  begin
    lk2.frame_strobe_n = 1'b1;
    lk2.mst_nibble_oe = 1'b0;
    lk2.mst_nibble_out = 4'h0;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    cmp_val(24'(arm), 24'h1);
    rd_data = 8'h3c;
    run_cycle(1'b0, 28'hf4c1234, 8'h00);
    cmp_val(24'(rdata), 24'h3c);
    cmp_val(24'({wire_q[17], wire_q[16]}), 24'h3c);
    cmp_val(24'({wire_q[2], wire_q[3], wire_q[9]}), 24'haf4);
    cmp_val(rd_addr, 24'h4c1234);
    cmp_val(24'({sel, rd_n[3:0]}), 24'h11);
    $display("test read done");
    run_cycle(1'b1, 28'h0210055, 8'h96);
    cmp_val(24'({wire_q[12], wire_q[11]}), 24'h96);
    cmp_val(24'({wire_q[13], wire_q[15]}), 24'hf0);
    cmp_val({wr_data, 8'(wr_n), 7'h0, sel}, 24'h960100);
    $display("test write done");
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    cmp_val(24'(arm), 24'h1);
    rd_data = 8'ha5;
    run_cycle(1'b0, 28'h0400000, 8'h00);
    cmp_val(24'({rdata, wire_q[14]}), 24'ha55);
    $display("test reset done");
    for (int k = 0; k < 6; k++)
    begin
      frame2(st_t[k], sl_t[k], sz_t[k], lo_t[k], ct_t[k]);
      cmp_val(24'(oe2_n), 24'(oe_t[k]));
      cmp_val(24'(rd2_n), 24'(rq_t[k]));
    end
    cmp_val(24'(stby2), 24'h1);
    $display("test faults done");
    complete_run();
  end
endmodule : hub_memory_cycle_target_test
